/* File: verilog/sec_error_checker.sv */
`timescale 1ns/1ps
module sec_error_checker (
	input  wire logic                             clk,
	input  wire logic                             reset_n,
	input  wire logic                             slaveMode,
	input  wire logic                             busValidN,
	input  wire logic [sec_pkg::CMD_W-1:0]        sysCommandBus,
	input  wire logic [sec_pkg::AD_W-1:0]         sysAddrDataBus,
	input  wire logic [sec_pkg::CHK_W-1:0]        sysAddrDataCheckBits,
	input  wire logic                             cycleIsAddress,
	input  wire logic                             dataForOwnRead,
	input  wire logic [sec_pkg::ENTRY_W-1:0]      dataEntry,
	input  wire logic [sec_pkg::DW_W-1:0]         dataDw,
	input  wire logic                             responseValidN,
	input  wire logic [sec_pkg::RESP_W-1:0]       sysResponseBus,
	input  wire logic                             responseParityBit,
	input  wire logic [sec_pkg::STATE_W-1:0]      sysStateBus,
	input  wire logic [sec_pkg::AD_W-1:0]         masterData,
	input  wire logic                             allocValid,
	input  wire logic [sec_pkg::ENTRY_W-1:0]      allocEntry,
	input  wire logic                             fwdValid,
	input  wire logic                             fwdBlock,
	input  wire logic [sec_pkg::ENTRY_W-1:0]      fwdEntry,
	input  wire logic [sec_pkg::DW_W-1:0]         fwdDw,
	input  wire logic [sec_pkg::SEC_IDX_W-1:0]    fwdIndex,
	input  wire logic                             wordReadIssued,
	input  wire logic                             softReset,
	input  wire logic                             statusClear,
	output logic                                  cmdValid,
	output logic      [sec_pkg::CMD_W-1:0]        cmdOut,
	output logic                                  adValid,
	output logic      [sec_pkg::AD_W-1:0]         adOut,
	output logic                                  respValid,
	output logic      [sec_pkg::RESP_W-1:0]       respOut,
	output logic                                  stateParityBit,
	output logic      [sec_pkg::CHK_W-1:0]        masterCheckBits,
	output logic                                  uncorrectableErrorN,
	output logic                                  correctableErrorN,
	output logic                                  cacheErrExc,
	output logic                                  busErrExc,
	output logic                                  sysAddressErrFlag,
	output logic                                  sysResponseErrFlag,
	output logic                                  externalErrorField,
	output logic      [sec_pkg::DW_W-1:0]         doublewordField,
	output logic      [sec_pkg::SEC_IDX_W-1:0]    secondaryIndexField,
	output logic                                  readStall
);
	typedef enum logic [2:0] {
		RD_IDLE = 3'b001,
		RD_WAIT = 3'b010,
		RD_HUNG = 3'b100
	} sec_rd_state_t;

	function automatic logic [sec_pkg::DW_W-1:0] firstSet(
		input logic [sec_pkg::DW_PER_ENTRY-1:0] f);
		firstSet = '0;
		for (int i = sec_pkg::DW_PER_ENTRY - 1; i >= 0; i--) begin
			if (f[i]) firstSet = i[sec_pkg::DW_W-1:0];
		end
	endfunction : firstSet

	// ****************************************************************
	// address/data check and decode
	// ****************************************************************
	logic [sec_pkg::AD_W-1:0]         corrData;
	logic                             eccCorr;
	logic                             eccUnc;
	logic                             busValid;
	logic                             checkEn;
	logic                             addrUnc;
	logic                             dataErrSet;
	logic                             respActive;
	logic                             respParErr;
	logic                             respOk;
	logic [sec_pkg::DW_PER_ENTRY-1:0] fwdFlags;
	logic                             blockErr;
	logic                             wordErr;
	logic [sec_pkg::DW_PER_ENTRY-1:0] flagsQ [sec_pkg::ENTRIES];

	sec_secded u_secded (
		.data          (sysAddrDataBus),
		.checkBits     (sysAddrDataCheckBits),
		.corrData      (corrData),
		.correctable   (eccCorr),
		.uncorrectable (eccUnc)
	);

	assign busValid   = ~busValidN;
	assign checkEn    = slaveMode & busValid & sysCommandBus[sec_pkg::CMD_CHK_EN_BIT];
	assign addrUnc    = checkEn & cycleIsAddress & eccUnc;
	assign dataErrSet = slaveMode & busValid & ~cycleIsAddress & dataForOwnRead
		& ((checkEn & eccUnc) | sysCommandBus[sec_pkg::CMD_DATA_QUAL_BIT]);
	assign respActive = ~responseValidN;
	assign respParErr = respActive & ~(^{sysResponseBus, responseParityBit});
	assign respOk     = respActive & ~respParErr;
	assign fwdFlags   = flagsQ[fwdEntry];
	assign blockErr   = fwdValid & fwdBlock & (|fwdFlags);
	assign wordErr    = fwdValid & ~fwdBlock & fwdFlags[fwdDw];

	// ****************************************************************
	// incoming buffer error flags
	// ****************************************************************
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int e = 0; e < sec_pkg::ENTRIES; e++) flagsQ[e] <= '0;
		end else begin
			for (int e = 0; e < sec_pkg::ENTRIES; e++) begin
				// a set in the same cycle as an allocation still wins
				if (allocValid && allocEntry == e[sec_pkg::ENTRY_W-1:0]) begin
					flagsQ[e] <= '0;
				end
				if (dataErrSet && dataEntry == e[sec_pkg::ENTRY_W-1:0]) begin
					flagsQ[e][dataDw] <= 1'b1;
				end
			end
		end
	end

	// ****************************************************************
	// accepted bus contents and error pins
	// ****************************************************************
	logic                         cmdValidQ;
	logic [sec_pkg::CMD_W-1:0]    cmdQ;
	logic                         adValidQ;
	logic [sec_pkg::AD_W-1:0]     adQ;
	logic                         respValidQ;
	logic [sec_pkg::RESP_W-1:0]   respQ;
	logic                         uncErrNQ;
	logic                         corErrNQ;
	logic                         cacheExcQ;
	logic                         busExcQ;
	logic                         stateParQ;
	logic [sec_pkg::CHK_W-1:0]    masterChkQ;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cmdValidQ  <= 1'b0;
			cmdQ       <= '0;
			adValidQ   <= 1'b0;
			adQ        <= '0;
			respValidQ <= 1'b0;
			respQ      <= '0;
			uncErrNQ   <= sec_pkg::RST_ERR_N;
			corErrNQ   <= sec_pkg::RST_ERR_N;
			cacheExcQ  <= 1'b0;
			busExcQ    <= 1'b0;
			stateParQ  <= 1'b1;
			masterChkQ <= '0;
		end else begin
			// dropping the cycle may desynchronise the cluster; accepted trade
			cmdValidQ  <= busValid & ~addrUnc;
			adValidQ   <= busValid & ~addrUnc;
			cmdQ       <= sysCommandBus;
			adQ        <= corrData;
			respValidQ <= respOk;
			respQ      <= sysResponseBus;
			uncErrNQ   <= ~(addrUnc | respParErr);
			corErrNQ   <= ~(checkEn & eccCorr);
			cacheExcQ  <= addrUnc | respParErr | blockErr;
			busExcQ    <= wordErr;
			stateParQ  <= ~(^sysStateBus);
			masterChkQ <= sec_pkg::eccGen(masterData);
		end
	end

	// ****************************************************************
	// cache error status fields
	// ****************************************************************
	logic                          addrFlagQ;
	logic                          respFlagQ;
	logic                          extErrQ;
	logic [sec_pkg::DW_W-1:0]      dwQ;
	logic [sec_pkg::SEC_IDX_W-1:0] indexQ;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			addrFlagQ <= sec_pkg::RST_FLAG;
			respFlagQ <= sec_pkg::RST_FLAG;
			extErrQ   <= sec_pkg::RST_FLAG;
			dwQ       <= '0;
			indexQ    <= '0;
		end else begin
			addrFlagQ <= addrUnc | (addrFlagQ & ~statusClear);
			respFlagQ <= respParErr | (respFlagQ & ~statusClear);
			extErrQ   <= blockErr | (extErrQ & ~statusClear);
			if (blockErr) begin
				dwQ    <= firstSet(fwdFlags);
				indexQ <= fwdIndex;
			end
		end
	end

	// ****************************************************************
	// outstanding word read tracking
	// ****************************************************************
	sec_rd_state_t rdStateQ;
	sec_rd_state_t rdStateD;

	always_comb begin
		case (rdStateQ)
			RD_IDLE: rdStateD = wordReadIssued ? RD_WAIT : RD_IDLE;
			RD_WAIT: begin
				if (respParErr) rdStateD = RD_HUNG;
				else if (respOk) rdStateD = RD_IDLE;
				else rdStateD = RD_WAIT;
			end
			RD_HUNG: rdStateD = RD_HUNG;
			default: rdStateD = RD_IDLE;
		endcase
		// only a soft reset or reset_n frees the hang; status fields survive the soft reset
		if (softReset) rdStateD = RD_IDLE;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) rdStateQ <= RD_IDLE;
		else rdStateQ <= rdStateD;
	end

	assign cmdValid            = cmdValidQ;
	assign cmdOut              = cmdQ;
	assign adValid             = adValidQ;
	assign adOut               = adQ;
	assign respValid           = respValidQ;
	assign respOut             = respQ;
	assign stateParityBit      = stateParQ;
	assign masterCheckBits     = masterChkQ;
	assign uncorrectableErrorN = uncErrNQ;
	assign correctableErrorN   = corErrNQ;
	assign cacheErrExc         = cacheExcQ;
	assign busErrExc           = busExcQ;
	assign sysAddressErrFlag   = addrFlagQ;
	assign sysResponseErrFlag  = respFlagQ;
	assign externalErrorField  = extErrQ;
	assign doublewordField     = dwQ;
	assign secondaryIndexField = indexQ;
	assign readStall           = (rdStateQ == RD_HUNG);

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	AST_ADDR_DROP: assert property (addrUnc |=> !cmdValid && !adValid)
		else $error("address ecc error did not drop the cycle");
	AST_ADDR_REPORT: assert property (addrUnc |=> sysAddressErrFlag && !uncorrectableErrorN
		&& cacheErrExc)
		else $error("address ecc error not reported");
	AST_UNC_ONE: assert property (!addrUnc && !respParErr |=> uncorrectableErrorN)
		else $error("uncorrectable pin low without cause");
	AST_FLAG_SET: assert property (dataErrSet |=> flagsQ[$past(dataEntry)][$past(dataDw)])
		else $error("incoming buffer flag not set");
	AST_BLOCK_EXC: assert property (blockErr |=> cacheErrExc && externalErrorField
		&& !busErrExc && secondaryIndexField == $past(fwdIndex))
		else $error("block forward error not raised");
	AST_WORD_EXC: assert property (wordErr |=> busErrExc
		&& cacheErrExc == $past(addrUnc || respParErr))
		else $error("word forward error not a bus error");
	AST_STATE_PAR: assert property (1'b1 |=> ^{stateParityBit, $past(sysStateBus)})
		else $error("state parity not odd");
	AST_RESP_PAR: assert property (respParErr |=> !respValid && sysResponseErrFlag
		&& !uncorrectableErrorN && cacheErrExc)
		else $error("response parity error not handled");
	AST_HANG: assert property (rdStateQ == RD_WAIT && respParErr && !softReset
		|=> readStall ##1 (readStall || $past(softReset)))
		else $error("read did not hang");
	AST_CHK_OFF: assert property (!checkEn |=> correctableErrorN)
		else $error("correction reported with checking off");
	AST_COR: assert property (checkEn && eccCorr |=> !correctableErrorN
		&& adOut == $past(corrData))
		else $error("correctable error not pulsed");
	AST_ALLOC: assert property (allocValid && !dataErrSet
		|=> flagsQ[$past(allocEntry)] == '0)
		else $error("allocated entry kept stale flags");

	COV_ADDR_ERR: cover property (addrUnc ##1 !uncorrectableErrorN);
	COV_BLOCK_ERR: cover property (dataErrSet ##[1:20] blockErr);
	COV_HANG: cover property (respParErr && rdStateQ == RD_WAIT ##1 readStall ##[1:30] softReset);

endmodule : sec_error_checker

/* File: shared/sec_pkg.sv */
package sec_pkg;

	// ****************************************************************
	// bus widths and buffer shape
	// ****************************************************************
	localparam int AD_W         = 64;
	localparam int CHK_W        = 8;
	localparam int CMD_W        = 12;
	localparam int RESP_W       = 5;
	localparam int STATE_W      = 3;
	localparam int ENTRIES      = 4;
	localparam int ENTRY_W      = 2;
	localparam int DW_PER_ENTRY = 4;
	localparam int DW_W         = 2;
	localparam int SEC_IDX_W    = 19;

	// ****************************************************************
	// command field positions
	// ****************************************************************
	localparam int CMD_CHK_EN_BIT    = 0;
	localparam int CMD_DATA_QUAL_BIT = 5;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic RST_ERR_N = 1'b1;
	localparam logic RST_FLAG  = 1'b0;

	// ****************************************************************
	// check matrix: 52 weight-3 and 12 weight-5 distinct columns,
	// chosen so that every row covers exactly 27 data bits
	// ****************************************************************
	localparam logic [7:0] EXCL_W3 [4]  = '{8'h07, 8'h38, 8'hc1, 8'h0e};
	localparam logic [7:0] W5_COMP [12] = '{8'h07, 8'h0e, 8'h1c, 8'h38, 8'h70, 8'he0,
		8'hc1, 8'h83, 8'h51, 8'ha2, 8'h34, 8'hc8};

	function automatic logic [7:0] colCode(input int idx);
		int         n;
		logic [7:0] v;
		logic       keep;
		colCode = 8'h00;
		n = 0;
		for (int c = 0; c < 256; c++) begin
			v = c[7:0];
			keep = 1'b0;
			if ($countones(v) == 3) begin
				keep = 1'b1;
				for (int k = 0; k < 4; k++) begin
					if (v == EXCL_W3[k]) keep = 1'b0;
				end
			end else if ($countones(v) == 5) begin
				for (int k = 0; k < 12; k++) begin
					if (~v == W5_COMP[k]) keep = 1'b1;
				end
			end
			if (keep) begin
				if (n == idx) colCode = v;
				n++;
			end
		end
	endfunction : colCode

	function automatic logic [CHK_W-1:0] eccGen(input logic [AD_W-1:0] data);
		logic [7:0] col;
		eccGen = '0;
		for (int i = 0; i < AD_W; i++) begin
			col = colCode(i);
			if (data[i]) eccGen = eccGen ^ col;
		end
	endfunction : eccGen

endpackage : sec_pkg

/* File: verilog/sec_secded.sv */
`timescale 1ns/1ps
module sec_secded (
	input  wire logic [sec_pkg::AD_W-1:0]  data,
	input  wire logic [sec_pkg::CHK_W-1:0] checkBits,
	output logic      [sec_pkg::AD_W-1:0]  corrData,
	output logic                           correctable,
	output logic                           uncorrectable
);
	logic [sec_pkg::CHK_W-1:0] syndrome;
	logic [sec_pkg::AD_W-1:0]  flip;
	logic                      chkBitHit;
	logic                      hit;

	assign syndrome = sec_pkg::eccGen(data) ^ checkBits;

	always_comb begin
		flip = '0;
		for (int i = 0; i < sec_pkg::AD_W; i++) begin
			flip[i] = (syndrome == sec_pkg::colCode(i));
		end
	end

	// a lone check-bit flip leaves the data intact but still counts as corrected
	assign chkBitHit     = ($countones(syndrome) == 1);
	assign hit           = (|flip) | chkBitHit;
	assign correctable   = hit;
	assign uncorrectable = (syndrome != '0) & ~hit;
	assign corrData      = data ^ flip;

endmodule : sec_secded

/* File: test/sec_agent_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// external agent: drives the address/data and response lines
// ****************************************************************
module sec_agent_model (
	input  wire logic                  clk,
	output logic                       busValidN,
	output logic [sec_pkg::CMD_W-1:0]  sysCommandBus,
	output logic [sec_pkg::AD_W-1:0]   sysAddrDataBus,
	output logic [sec_pkg::CHK_W-1:0]  sysAddrDataCheckBits,
	output logic                       responseValidN,
	output logic [sec_pkg::RESP_W-1:0] sysResponseBus,
	output logic                       responseParityBit
);
	logic [7:0] cols [64];

	// table built once; rebuilding it per call would slow every cycle
	initial begin
		int         n;
		logic [7:0] v;
		logic       keep;
		n = 0;
		busValidN = 1'b1;
		responseValidN = 1'b1;
		sysCommandBus = '0;
		sysAddrDataBus = '0;
		sysAddrDataCheckBits = '0;
		sysResponseBus = '0;
		responseParityBit = 1'b1;
		for (int c = 0; c < 256; c++) begin
			v = c[7:0];
			keep = ($countones(v) == 3);
			for (int k = 0; k < 4; k++) begin
				if (v == sec_pkg::EXCL_W3[k]) keep = 1'b0;
			end
			for (int k = 0; k < 12; k++) begin
				if ($countones(v) == 5 && (~v) == sec_pkg::W5_COMP[k]) keep = 1'b1;
			end
			if (keep && n < 64) begin
				cols[n] = v;
				n++;
			end
		end
	end

	function automatic logic [7:0] ecc(input logic [63:0] d);
		ecc = 8'h00;
		for (int i = 0; i < 64; i++) begin
			if (d[i]) ecc = ecc ^ cols[i];
		end
	endfunction : ecc

	// idle a cycle, drive one cycle, release; flip corrupts data after coding
	task automatic adCycle(input logic [11:0] cmd, input logic [63:0] d, input logic [63:0] flip);
		@(negedge clk);
		busValidN = 1'b0;
		sysCommandBus = cmd;
		sysAddrDataBus = d ^ flip;
		sysAddrDataCheckBits = ecc(d);
		@(negedge clk);
		// released lines show the inverse so a stale value never matches
		busValidN = 1'b1;
		sysCommandBus = ~cmd;
		sysAddrDataBus = ~sysAddrDataBus;
		sysAddrDataCheckBits = ~sysAddrDataCheckBits;
	endtask : adCycle

	task automatic respCycle(input logic [4:0] r, input logic badPar);
		@(negedge clk);
		responseValidN = 1'b0;
		sysResponseBus = r;
		responseParityBit = ~^r ^ badPar;
		@(negedge clk);
		responseValidN = 1'b1;
		sysResponseBus = ~r;
		responseParityBit = ~responseParityBit;
	endtask : respCycle
endmodule : sec_agent_model

/* File: test/sec_error_checker_tb_top.sv */
`timescale 1ns/1ps
module sec_error_checker_tb_top;
	logic                        clk, reset_n, slaveMode, cycleIsAddress, dataForOwnRead;
	logic                        allocValid, fwdValid, fwdBlock, wordReadIssued, softReset;
	logic                        statusClear, busValidN, responseValidN, responseParityBit;
	logic [sec_pkg::CMD_W-1:0]   sysCommandBus, cmdOut;
	logic [sec_pkg::AD_W-1:0]    sysAddrDataBus, masterData, adOut;
	logic [sec_pkg::CHK_W-1:0]   sysAddrDataCheckBits, masterCheckBits;
	logic [sec_pkg::ENTRY_W-1:0] dataEntry, allocEntry, fwdEntry;
	logic [sec_pkg::DW_W-1:0]    dataDw, fwdDw, doublewordField;
	logic [sec_pkg::RESP_W-1:0]  sysResponseBus, respOut;
	logic [sec_pkg::STATE_W-1:0] sysStateBus;
	logic [sec_pkg::SEC_IDX_W-1:0] fwdIndex, secondaryIndexField;
	logic                        cmdValid, adValid, respValid, stateParityBit, readStall;
	logic                        uncorrectableErrorN, correctableErrorN, cacheErrExc, busErrExc;
	logic                        sysAddressErrFlag, sysResponseErrFlag, externalErrorField;
	int                          n_fail, n_compared;
	localparam logic [63:0]      DATA = 64'h0123_4567_89ab_cdef;

	sec_agent_model i_agent (
		.clk, .busValidN, .sysCommandBus, .sysAddrDataBus, .sysAddrDataCheckBits,
		.responseValidN, .sysResponseBus, .responseParityBit
	);
	sec_error_checker i_dut (
		.clk, .reset_n, .slaveMode, .busValidN, .sysCommandBus, .sysAddrDataBus,
		.sysAddrDataCheckBits, .cycleIsAddress, .dataForOwnRead, .dataEntry, .dataDw,
		.responseValidN, .sysResponseBus, .responseParityBit, .sysStateBus, .masterData,
		.allocValid, .allocEntry, .fwdValid, .fwdBlock, .fwdEntry, .fwdDw, .fwdIndex,
		.wordReadIssued, .softReset, .statusClear, .cmdValid, .cmdOut, .adValid, .adOut,
		.respValid, .respOut, .stateParityBit, .masterCheckBits, .uncorrectableErrorN,
		.correctableErrorN, .cacheErrExc, .busErrExc, .sysAddressErrFlag, .sysResponseErrFlag,
		.externalErrorField, .doublewordField, .secondaryIndexField, .readStall
	);

	always #2.5 clk = ~clk;

	// ****************************************************************
	// helpers
	// ****************************************************************
	task automatic check(input logic [63:0] got, input logic [63:0] exp, input string msg);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask : check

	task automatic checkBit(input logic got, input logic exp, input string msg);
		check(64'(got), 64'(exp), msg);
	endtask : checkBit

	task automatic forward(input logic blk, input logic [1:0] e, input logic [1:0] dw);
		@(negedge clk);
		fwdValid = 1'b1;
		fwdBlock = blk;
		fwdEntry = e;
		fwdDw = dw;
		@(negedge clk);
		fwdValid = 1'b0;
	endtask : forward

	task automatic alloc(input logic [1:0] e);
		@(negedge clk);
		allocValid = 1'b1;
		allocEntry = e;
		@(negedge clk);
		allocValid = 1'b0;
	endtask : alloc

	task automatic finish_test();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : finish_test

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		{clk, reset_n, slaveMode, cycleIsAddress, dataForOwnRead, allocValid} = '0;
		{fwdValid, fwdBlock, wordReadIssued, softReset, statusClear} = '0;
		{masterData, dataEntry, allocEntry, fwdEntry, dataDw, fwdDw, sysStateBus} = '0;
		fwdIndex = 19'h5a5a5;
		n_fail = 0;
		n_compared = 0;
		repeat (10) @(posedge clk);
		@(negedge clk);
		reset_n = 1'b1;
		checkBit(uncorrectableErrorN & correctableErrorN & stateParityBit, 1'b1, "reset pins");
		checkBit(cmdValid | adValid | respValid | cacheErrExc | busErrExc | readStall
			| sysAddressErrFlag | sysResponseErrFlag, 1'b0, "reset outputs");
		for (int s = 0; s < 8; s++) begin
			sysStateBus = 3'(s);
			@(negedge clk);
			checkBit(stateParityBit, ~^sysStateBus, "state parity");
		end
		masterData = '1;
		@(negedge clk);
		check(64'(masterCheckBits), 64'hff, "all-ones code");
		for (int i = 0; i < 64; i++) begin
			masterData = 64'h1 << i;
			@(negedge clk);
			check(64'(masterCheckBits), 64'(i_agent.ecc(masterData)), "column code");
		end
		slaveMode = 1'b1;
		cycleIsAddress = 1'b1;
		i_agent.adCycle(12'h001, DATA, 64'h80);
		checkBit(~correctableErrorN & cmdValid, 1'b1, "correctable pulse");
		check(adOut, DATA, "corrected data");
		check(64'(cmdOut), 64'h001, "command copy");
		@(negedge clk);
		checkBit(correctableErrorN, 1'b1, "correctable width");
		i_agent.adCycle(12'h000, DATA, 64'h3);
		checkBit(uncorrectableErrorN, 1'b1, "checking disabled");
		slaveMode = 1'b0;
		i_agent.adCycle(12'h001, DATA, 64'h3);
		checkBit(uncorrectableErrorN, 1'b1, "master state");
		slaveMode = 1'b1;
		i_agent.adCycle(12'h001, DATA, 64'h3);
		checkBit(cmdValid | adValid, 1'b0, "address cycle dropped");
		checkBit(uncorrectableErrorN | ~cacheErrExc, 1'b0, "uncorrectable report");
		checkBit(sysAddressErrFlag, 1'b1, "address flag");
		@(negedge clk);
		checkBit(uncorrectableErrorN & ~cacheErrExc & sysAddressErrFlag, 1'b1, "one cycle");
		statusClear = 1'b1;
		@(negedge clk);
		statusClear = 1'b0;
		checkBit(sysAddressErrFlag, 1'b0, "status clear");
		// ****************************************************************
		// incoming buffer flags and forwarding
		// ****************************************************************
		cycleIsAddress = 1'b0;
		dataForOwnRead = 1'b1;
		dataEntry = 2'd1;
		dataDw = 2'd2;
		i_agent.adCycle(12'h001, DATA, 64'h3);
		checkBit(adValid, 1'b1, "data cycle kept");
		dataEntry = 2'd2;
		dataDw = 2'd1;
		i_agent.adCycle(12'h020, DATA, 64'h0);
		dataForOwnRead = 1'b0;
		dataEntry = 2'd3;
		i_agent.adCycle(12'h021, DATA, 64'h3);
		forward(1'b1, 2'd1, 2'd0);
		checkBit(cacheErrExc & ~busErrExc & externalErrorField, 1'b1, "block error");
		check(64'(doublewordField), 64'h2, "doubleword field");
		check(64'(secondaryIndexField), 64'(fwdIndex), "index field");
		@(negedge clk);
		checkBit(cacheErrExc, 1'b0, "single cache error");
		forward(1'b0, 2'd2, 2'd0);
		checkBit(busErrExc | cacheErrExc, 1'b0, "clean doubleword");
		forward(1'b0, 2'd2, 2'd1);
		checkBit(busErrExc & ~cacheErrExc, 1'b1, "bus error");
		forward(1'b1, 2'd3, 2'd0);
		checkBit(cacheErrExc, 1'b0, "foreign data cycle");
		alloc(2'd2);
		forward(1'b0, 2'd2, 2'd1);
		checkBit(busErrExc, 1'b0, "stale flag cleared");
		// ****************************************************************
		// response path and hang recovery
		// ****************************************************************
		i_agent.respCycle(5'h0b, 1'b0);
		checkBit(respValid, 1'b1, "good response");
		check(64'(respOut), 64'h0b, "response value");
		i_agent.respCycle(5'h0b, 1'b1);
		checkBit(respValid | uncorrectableErrorN | ~cacheErrExc, 1'b0, "bad parity");
		checkBit(sysResponseErrFlag & ~readStall, 1'b1, "response flag");
		@(negedge clk);
		checkBit(uncorrectableErrorN, 1'b1, "idle parity ignored");
		statusClear = 1'b1;
		@(negedge clk);
		statusClear = 1'b0;
		checkBit(sysResponseErrFlag, 1'b0, "status clear");
		wordReadIssued = 1'b1;
		@(negedge clk);
		wordReadIssued = 1'b0;
		i_agent.respCycle(5'h03, 1'b1);
		checkBit(readStall, 1'b1, "read hangs");
		repeat (20) @(negedge clk);
		checkBit(readStall, 1'b1, "still hung");
		softReset = 1'b1;
		@(negedge clk);
		softReset = 1'b0;
		checkBit(readStall, 1'b0, "soft reset recovers");
		checkBit(sysResponseErrFlag, 1'b1, "status after recovery");
		finish_test();
	end

	// hang guard
	initial begin
		repeat (5000) @(posedge clk);
		n_fail++;
		$display("BAD %0t run did not finish", $time);
		finish_test();
	end
endmodule : sec_error_checker_tb_top
